// ### design/capture_dma_event_count_ctrl.v
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`include "capture_dma_regs.vh"

module capture_dma_event_count_ctrl (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // avalon-mm slave
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [3:0]  avs_byteenable_i,
  input  wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // capture datapath, same clock
  input  wire        fifo_dword_written_i,
  input  wire        frame_start_i,
  input  wire        field2_active_i,
  input  wire        dma_first_read_i,
  input  wire        dma_busy_i,
  // requests and fifo control
  output wire        luma_request_event_o,
  output wire        blue_chroma_request_event_o,
  output wire        red_chroma_request_event_o,
  output wire        fifo_flush_o,
  output wire        capture_enable_o,
  output wire [9:0]  active_threshold_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state encodings

  localparam CH_IDLE  = 2'h0;
  localparam CH_DRAIN = 2'h1;
  localparam CH_FLUSH = 2'h2;

  localparam BK_BLOCKED = 2'h0;
  localparam BK_WAIT1   = 2'h1;
  localparam BK_WAIT2   = 2'h2;
  localparam BK_RUN     = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [31:0] thr_r;
  reg [31:0] evt_r;
  reg [31:0] ctl_r;
  reg [31:0] rdata_r;
  reg        ack_r;
  reg [1:0]  ch_state_r;
  reg [3:0]  flush_cnt_r;
  reg [1:0]  bk_state_r;
  reg [11:0] set_cnt_r;
  reg        use_f2_r;
  reg [9:0]  dw_cnt_r;
  reg        hold_r;
  reg        req_r;
  reg        flush_r;

  // byte-lane merge of a write into a stored word
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          lane_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls

  wire        cmd      = (avs_read_i | avs_write_i) & ~ack_r;
  // a write lands at the edge where waitrequest is sampled low
  wire        wr_hit   = avs_write_i & ack_r;
  wire [31:0] wmerge_thr = lane_merge(thr_r, avs_writedata_i,
                                      avs_byteenable_i);
  wire [31:0] wmerge_evt = lane_merge(evt_r, avs_writedata_i,
                                      avs_byteenable_i);
  wire [31:0] wmerge_ctl = lane_merge(ctl_r, avs_writedata_i,
                                      avs_byteenable_i);
  wire        rst_wr   = wr_hit && avs_address_i == `OFS_CONTROL &&
                         avs_byteenable_i[3] &&
                         avs_writedata_i[`CTL_RESET_BIT];
  wire        ch_reset = ctl_r[`CTL_RESET_BIT];
  wire        blocked  = ctl_r[`CTL_BLOCK_BIT];
  wire [1:0]  mode     = ctl_r[`CTL_MODE_LSB +: 2];
  wire        paced    = (mode == `MODE_YC);
  wire [9:0]  thr1     = thr_r[`THR1_LSB +: `THR_W];
  wire [9:0]  thr2     = thr_r[`THR2_LSB +: `THR_W];
  wire [9:0]  thr_sel  = (use_f2_r & ctl_r[`CTL_T2EN_BIT] & paced) ?
                         thr2 : thr1;
  wire [11:0] evt_lim  = use_f2_r ? evt_r[`EVT2_LSB +: `EVT_W]
                                  : evt_r[`EVT1_LSB +: `EVT_W];
  wire        may_req  = ctl_r[`CTL_EN_BIT] & ~ch_reset &
                         (bk_state_r == BK_RUN);
  wire        thr_hit  = fifo_dword_written_i && thr_sel != 10'h000 &&
                         dw_cnt_r + 10'h001 >= thr_sel;

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on the second edge

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= cmd;
      if (avs_read_i & ~ack_r) begin
        if (avs_address_i == `OFS_THRESHOLD) begin
          rdata_r <= thr_r;
        end else if (avs_address_i == `OFS_EVENT_COUNT) begin
          rdata_r <= evt_r;
        end else if (avs_address_i == `OFS_CONTROL) begin
          rdata_r <= ctl_r;
        end else if (avs_address_i == `OFS_STATUS) begin
          rdata_r <= {16'h0000, use_f2_r, 3'h0, set_cnt_r};
        end else begin
          rdata_r <= 32'h0000_0000; // unmapped reads zero
        end
      end
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // programmable registers; channel reset restores them all

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_r <= `THR_RESET;
      evt_r <= `EVT_RESET;
      ctl_r <= `CTL_RESET_VAL;
    end else if (ch_state_r == CH_FLUSH && flush_cnt_r == 4'h0) begin
      thr_r <= `THR_RESET;
      evt_r <= `EVT_RESET;
      ctl_r <= `CTL_RESET_VAL;
    end else if (rst_wr) begin
      // the reset bit latches and enable drops at once
      ctl_r[`CTL_RESET_BIT] <= 1'b1;
      ctl_r[`CTL_EN_BIT]    <= 1'b0;
    end else if (wr_hit & ~ch_reset) begin
      if (avs_address_i == `OFS_THRESHOLD) begin
        thr_r <= wmerge_thr & 32'h03ff_03ff;
      end else if (avs_address_i == `OFS_EVENT_COUNT) begin
        evt_r <= wmerge_evt & 32'h0fff_0fff;
      end else if (avs_address_i == `OFS_CONTROL) begin
        ctl_r <= wmerge_ctl & `CTL_RW_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel reset sequence: drain pending transfers, then flush

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_state_r  <= CH_IDLE;
      flush_cnt_r <= 4'h0;
    end else begin
      case (ch_state_r)
        CH_IDLE: begin
          if (ch_reset) begin
            ch_state_r <= CH_DRAIN;
          end
        end
        CH_DRAIN: begin
          if (~dma_busy_i) begin
            ch_state_r  <= CH_FLUSH;
            flush_cnt_r <= `FLUSH_CYCLES - 4'h1;
          end
        end
        CH_FLUSH: begin
          if (flush_cnt_r == 4'h0) begin
            ch_state_r <= CH_IDLE;
          end else begin
            flush_cnt_r <= flush_cnt_r - 4'h1;
          end
        end
        default: begin
          ch_state_r <= CH_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture block: requests resume at the first frame start after the
  // clear, so the rest of the frame in which the bit cleared is skipped

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bk_state_r <= BK_BLOCKED;
    end else if (blocked) begin
      bk_state_r <= BK_BLOCKED;
    end else begin
      case (bk_state_r)
        BK_BLOCKED: begin
          bk_state_r <= BK_WAIT1;
        end
        BK_WAIT1: begin
          if (frame_start_i) begin
            bk_state_r <= BK_RUN;
          end
        end
        BK_WAIT2: begin
          bk_state_r <= BK_WAIT1;
        end
        default: begin
          bk_state_r <= bk_state_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request pacing: double word counter, hold until first read, set count

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dw_cnt_r  <= 10'h000;
      hold_r    <= 1'b0;
      req_r     <= 1'b0;
      set_cnt_r <= 12'h000;
      use_f2_r  <= 1'b0;
    end else if (~may_req) begin
      // no request may be made (enable low, channel reset, or block not yet run), so pacing state starts over
      dw_cnt_r  <= 10'h000;
      hold_r    <= 1'b0;
      req_r     <= 1'b0;
      set_cnt_r <= 12'h000;
      use_f2_r  <= 1'b0;
    end else begin
      req_r <= 1'b0;
      if (dma_first_read_i) begin
        hold_r <= 1'b0;
      end
      if (thr_hit) begin
        dw_cnt_r <= 10'h000;
      end else if (fifo_dword_written_i) begin
        dw_cnt_r <= dw_cnt_r + 10'h001;
      end
      if (thr_hit && (~hold_r || dma_first_read_i)) begin
        req_r  <= 1'b1;
        hold_r <= 1'b1;
        if (paced && set_cnt_r + 12'h001 >= evt_lim) begin
          set_cnt_r <= 12'h000;
          use_f2_r  <= ~use_f2_r;
        end else if (paced) begin
          set_cnt_r <= set_cnt_r + 12'h001;
        end
      end
      if (paced && frame_start_i && ~field2_active_i) begin
        use_f2_r  <= 1'b0;
        set_cnt_r <= 12'h000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flush_r <= 1'b1;
    end else begin
      flush_r <= blocked | (ch_state_r == CH_FLUSH);
    end
  end

  reg en_r;
  reg [9:0] athr_r;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_r   <= 1'b0;
      athr_r <= 10'h000;
    end else begin
      en_r   <= ctl_r[`CTL_EN_BIT];
      athr_r <= thr_sel;
    end
  end

  // all three requests share one flop so a set is always whole
  assign luma_request_event_o        = req_r;
  assign blue_chroma_request_event_o = req_r;
  assign red_chroma_request_event_o  = req_r;
  assign fifo_flush_o                = flush_r;
  assign capture_enable_o            = en_r;
  assign active_threshold_o          = athr_r;

endmodule

// ### design/capture_dma_regs.vh
// Summary of operation
// - field-1 event-set count, 12 bits at 11:0, resets to zero.
// - field-2 event-set count, 12 bits at 27:16, resets to zero.
// - one event set is one luma plus one each of two chroma requests.
// - internal counter of issued sets selects threshold for events and data.
// - reaching the field's set count switches to the other field's threshold.
// - reserved event count bits read zero, writes ignored.
// - channel reset bit 31 is write-one; zero does nothing; reads zero. Here it reads one until the reset sequence ends.
// - channel reset stops requests, flushes FIFO after pending transfers finish.
// - channel reset clears capture enable.
// - channel reset returns all channel registers to reset values.
// - channel reset bit clears itself when the reset sequence ends.
// - capture block bit 30 resets to one; blocks requests, resets FIFOs.
// - after block clears, requests resume in the frame after the clearing one.
// - after block clears, logic syncs to the next frame start first.
// - control reset: inversion 0, vmethod 1, hmethod 0, enable 0, fields 1.
// - threshold fields 9:0 and 25:16 count double words per request.
// - field-2 threshold enable clear means field-1 threshold for both fields.
// - after threshold, hold requests until the controller's first FIFO read.
`ifndef CAPTURE_DMA_REGS_VH
`define CAPTURE_DMA_REGS_VH

// register byte offsets on the avalon slave
`define OFS_THRESHOLD   4'h0
`define OFS_EVENT_COUNT 4'h4
`define OFS_CONTROL     4'h8
`define OFS_STATUS      4'hc

// threshold register fields
`define THR1_LSB        0
`define THR2_LSB        16
`define THR_W           10
`define THR_RESET       32'h0000_0000

// event count register fields
`define EVT1_LSB        0
`define EVT2_LSB        16
`define EVT_W           12
`define EVT_RESET       32'h0000_0000

// control register fields
`define CTL_RESET_BIT   31
`define CTL_BLOCK_BIT   30
`define CTL_FIELD_INVERSION_BIT    20
`define CTL_VERTICAL_COUNT_RESET_METHOD_BIT    17
`define CTL_HORIZONTAL_COUNT_RESET_METHOD_BIT    16
`define CTL_EN_BIT      15
`define CTL_T2EN_BIT    8
`define CTL_F2_BIT      5
`define CTL_F1_BIT      4
`define CTL_MODE_LSB    0
`define CTL_RW_MASK     32'h4013_8133
`define CTL_RESET_VAL   32'h4002_0030

// capture modes in control bits 1:0
`define MODE_YC         2'h0
`define MODE_RAW        2'h1
`define MODE_SINGLE     2'h2

// cycles taken by the flush once transfers are drained
`define FLUSH_CYCLES    4'h4

`endif

// ### tb/capture_dma_checker.sv
`timescale 1ns/10ps
module capture_dma_checker (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // register bus
  input wire [3:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  // capture side
  input wire        frame_start_i,
  input wire        luma_request_event_o,
  input wire        blue_chroma_request_event_o,
  input wire        red_chroma_request_event_o,
  input wire        fifo_flush_o,
  input wire        capture_enable_o
);
  reg armed_r;
  // hold-off window: block lifted, frame start not seen yet
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      armed_r <= 1'b0;
    else if (frame_start_i)
      armed_r <= 1'b0;
    else if ($fell(fifo_flush_o))
      armed_r <= 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // accepted control writes, lane 3 carries both action bits
  sequence ctl_wr_s;
    avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h8
      && avs_byteenable_i[3];
  endsequence
  sequence rst_wr_s;
    ctl_wr_s ##0 avs_writedata_i[31];
  endsequence
  sequence blk_wr_s;
    ctl_wr_s ##0 !avs_writedata_i[31] && avs_writedata_i[30];
  endsequence
  chk_enable_drop: assert property (
    rst_wr_s |-> ##[1:2] !capture_enable_o) else $error("enable kept");
  chk_block_flush: assert property (
    blk_wr_s |-> ##[1:2] fifo_flush_o) else $error("no flush on block");
  chk_set_whole: assert property (
    luma_request_event_o == blue_chroma_request_event_o
      && luma_request_event_o == red_chroma_request_event_o)
    else $error("event set split");
  chk_no_req_flush: assert property (
    fifo_flush_o |-> !luma_request_event_o) else $error("event in flush");
  chk_req_gap: assert property (
    luma_request_event_o |=> !luma_request_event_o)
    else $error("events back to back");
  chk_resume_frame: assert property (
    armed_r |-> !luma_request_event_o) else $error("event before frame");
  chk_reserved_zero: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h4
      |-> avs_readdata_o[31:28] == 4'h0 && avs_readdata_o[15:12] == 4'h0)
    else $error("reserved bits set");
  chk_wait_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
endmodule
bind capture_dma_event_count_ctrl capture_dma_checker u_chk (
  .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .frame_start_i, .luma_request_event_o, .blue_chroma_request_event_o,
  .red_chroma_request_event_o, .fifo_flush_o, .capture_enable_o);

// ### tb/dma_partner.sv
`timescale 1ns/10ps
module dma_partner #(parameter int DLY = 3) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // request in, slow service select
  input  wire logic req_i,
  input  wire logic slow_i,
  // service out
  output logic      first_read_o,
  output logic      busy_o
);
  int cnt_r;
  // each event is serviced: busy until its first fifo read
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 0;
      first_read_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      first_read_o <= (cnt_r == 1);
      busy_o <= req_i || cnt_r > 1;
      if (req_i)
        cnt_r <= slow_i ? 4 * DLY : DLY;
      else if (cnt_r > 0)
        cnt_r <= cnt_r - 1;
    end
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic fifo_dword_written_i = 0, frame_start_i = 0, slow = 0;
  logic [3:0] avs_address_i = 0, avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 0, q;
  wire [31:0] avs_readdata_o;
  wire [9:0] active_threshold_o;
  wire avs_waitrequest_o, luma_request_event_o, fifo_flush_o;
  wire capture_enable_o, dma_first_read_i, dma_busy_i;
  int err_count = 0, n_compared = 0, ev = 0, e;
  always #20 clk_i = ~clk_i;
  // count event sets seen on the luma line
  always @(posedge clk_i) if (luma_request_event_o) ev <= ev + 1;
  capture_dma_event_count_ctrl u_dut (.clk_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .fifo_dword_written_i,
    .frame_start_i, .field2_active_i(1'b0), .dma_first_read_i, .dma_busy_i,
    .luma_request_event_o, .blue_chroma_request_event_o(),
    .red_chroma_request_event_o(), .fifo_flush_o, .capture_enable_o,
    .active_threshold_o);
  dma_partner u_dma (.clk_i, .rst_i, .req_i(luma_request_event_o),
    .slow_i(slow), .first_read_o(dma_first_read_i), .busy_o(dma_busy_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus transfer: hold the request until waitrequest is sampled low,
  // take read data at that edge, then let one edge pass before the next
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    q = avs_readdata_o;
    avs_write_i <= 0;
    avs_read_i  <= 0;
    @(posedge clk_i);
  endtask
  task automatic push(input int n);
    repeat (n) begin
      fifo_dword_written_i <= 1;
      @(posedge clk_i);
    end
    fifo_dword_written_i <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic frame();
    frame_start_i <= 1;
    @(posedge clk_i);
    frame_start_i <= 0;
    repeat (2) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(0, 4'h8, 0); cmp(q, 32'h4002_0030);
    bus(0, 4'h4, 0); cmp(q, 32'h0);
    bus(1, 4'h4, 32'hffff_ffff);
    bus(0, 4'h4, 0); cmp(q, 32'h0fff_0fff);
    bus(0, 4'h2, 0); cmp(q, 32'h0);
  endtask
  task automatic t_pace();
    bus(1, 4'h0, 32'h0003_0002);
    bus(1, 4'h4, 32'h0001_0001);
    bus(1, 4'h8, 32'h0002_8130);
    frame();
    push(2); cmp(ev, 1);
    cmp(active_threshold_o, 32'h3);
    bus(0, 4'hc, 0); cmp(q, 32'h0000_8000);
    repeat (20) @(posedge clk_i);
    push(2); cmp(ev, 1);
    push(1); cmp(ev, 2);
    // raw mode: set counts ignored, field-1 threshold for every event
    bus(1, 4'h8, 32'h0002_8131);
    e = ev;
    push(2);
    repeat (4) @(posedge clk_i);
    push(2); cmp(ev, e + 2);
    cmp(active_threshold_o, 32'h2);
  endtask
  task automatic t_block();
    bus(1, 4'h8, 32'h4002_8130);
    @(posedge clk_i); cmp(fifo_flush_o, 1);
    bus(0, 4'h0, 0); cmp(q, 32'h0003_0002);
  endtask
  // reset during a slow transfer: flush must wait for it
  task automatic t_chan();
    slow <= 1;
    bus(1, 4'h8, 32'h0002_8130);
    frame();
    e = ev;
    push(2); cmp(ev, e + 1);
    cmp(capture_enable_o, 1);
    bus(1, 4'h8, 32'h8000_0000);
    @(posedge clk_i); cmp(capture_enable_o, 0);
    cmp(fifo_flush_o, 0);
    repeat (40) @(posedge clk_i);
    bus(0, 4'h8, 0); cmp(q, 32'h4002_0030);
    bus(0, 4'h0, 0); cmp(q, 32'h0);
    cmp(fifo_flush_o, 1);
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_regs();
    t_pace();
    t_block();
    t_chan();
    conclude();
  end
  // the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    conclude();
  end
endmodule
